// ### hw/cfl_lock_detector.sv
// cfl_lock_detector: frequency acquisition sweep and loss-of-lock control.
// assumes pins arrive asynchronously and control words come from clk logic.
`timescale 1ns/1ns
`default_nettype none
module cfl_lock_detector #(
   parameter int WINDOW_CYC = cfl_pkg::WIN_CYC_DEF
) (
   input  wire logic                    clk,
   input  wire logic                    rst,
   input  wire logic                    osc_tick_pin,
   input  wire logic                    data_pin,
   input  wire logic                    acquisition_aid_clock,
   input  wire logic [7:0]              primary_control_word,
   input  wire logic [7:0]              secondary_control_word,
   output logic                         loss_of_lock,
   output logic                         lol_sticky,
   output logic                         freq_loop_en,
   output logic                         phase_loop_en,
   output logic [cfl_pkg::CODE_W-1:0]   osc_code
);
   import cfl_pkg::*;
   generate
      if (WINDOW_CYC < 16 || WINDOW_CYC >= (1 << WIN_CW)) begin : g_chk
         $error("cfl_lock_detector: WINDOW_CYC out of range");
      end
   endgenerate

   // window timing
   logic [WIN_CW-1:0] win_reg, win_next;
   logic              win_end, eval_reg, eval_next;
   always_comb begin
      win_end = (win_reg == WIN_CW'(WINDOW_CYC - 1));
      win_next = win_end ? '0 : win_reg + 1'b1;
      eval_next = win_end;              // counts settle one cycle later
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         win_reg <= '0;
         eval_reg <= 1'b0;
      end else begin
         win_reg <= win_next;
         eval_reg <= eval_next;
      end
   end

   // edge counts for oscillator, data transitions and reference
   logic [CNT_W-1:0] osc_cnt, data_cnt, ref_cnt;
   cfl_edge_counter #(.CW(CNT_W), .BOTH_EDGES(1'b0)) u_osc (
      .clk(clk), .rst(rst), .pin_async(osc_tick_pin), .win_end(win_end), .count(osc_cnt));
   cfl_edge_counter #(.CW(CNT_W), .BOTH_EDGES(1'b1)) u_data (
      .clk(clk), .rst(rst), .pin_async(data_pin), .win_end(win_end), .count(data_cnt));
   cfl_edge_counter #(.CW(CNT_W), .BOTH_EDGES(1'b0)) u_ref (
      .clk(clk), .rst(rst), .pin_async(acquisition_aid_clock), .win_end(win_end),
      .count(ref_cnt));

   // frequency comparison; ranges unchecked until software sets them
   logic             aid_mode;
   logic [1:0]       ref_range;
   logic [3:0]       ref_ratio;
   logic [TGT_W-1:0] tgt, oscw, diff;
   logic             too_low, out_of_lock, in_lock, near1, near2;
   logic [3:0]       step_sh;
   always_comb begin
      aid_mode  = primary_control_word[CA_AID_BIT];
      ref_range = primary_control_word[CA_RANGE_LO +: 2];
      ref_ratio = primary_control_word[CA_RATIO_LO +: 4];
      // divided-down reference scaled by ratio, or raw data transitions
      if (aid_mode)
         tgt = (TGT_W'(ref_cnt) >> ref_range) << ref_ratio;
      else
         tgt = TGT_W'(data_cnt);
      oscw = TGT_W'(osc_cnt);
      too_low = oscw < tgt;
      diff = too_low ? tgt - oscw : oscw - tgt;
      // ppm tests done in 64 bits to avoid overflow
      out_of_lock = (64'(diff) * PPM_SCALE) > (64'(tgt) * PPM_ASSERT);
      in_lock = (tgt != '0) && ((64'(diff) * PPM_SCALE) <= (64'(tgt) * PPM_LOCK));
      near1 = (64'(diff) * NEAR_DIV1) <= 64'(tgt);
      near2 = (64'(diff) * NEAR_DIV2) <= 64'(tgt);
      step_sh = near2 ? SH_FINE : (near1 ? SH_MEDIUM : SH_COARSE);
   end

   // acquisition state; overshoot restarts the sweep with finer steps
   cfl_state_t       state_reg, state_next;
   logic [CODE_W-1:0] code_reg, code_next, step_val;
   logic [3:0]       shrink_reg, shrink_next;
   logic             lol_reg, lol_next;
   logic [CODE_W:0]  code_sum;
   always_comb begin
      state_next = state_reg;
      code_next = code_reg;
      shrink_next = shrink_reg;
      lol_next = lol_reg;
      step_val = (step_sh > shrink_reg) ? (CODE_W'(1) << (step_sh - shrink_reg)) : CODE_W'(1);
      code_sum = {1'b0, code_reg} + {1'b0, step_val};
      if (eval_reg) begin
         case (state_reg)
            CFL_LOCKED: begin
               if (out_of_lock) begin
                  state_next = CFL_ACQUIRE;
                  lol_next = 1'b1;
                  code_next = CODE_FLOOR;
                  shrink_next = 4'h0;
               end
            end
            CFL_ACQUIRE: begin
               if (in_lock) begin
                  state_next = CFL_LOCKED;
                  lol_next = 1'b0;
               end else if (too_low) begin
                  // saturate at top of range
                  if (code_sum > {1'b0, CODE_CEIL})
                     code_next = CODE_CEIL;
                  else
                     code_next = code_sum[CODE_W-1:0];
               end else begin
                  code_next = CODE_FLOOR;
                  if (shrink_reg != SH_MAXOFF)
                     shrink_next = shrink_reg + 1'b1;
               end
            end
            default: begin
               state_next = CFL_ACQUIRE;
               lol_next = 1'b1;
               code_next = CODE_FLOOR;
            end
         endcase
      end
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= CFL_ACQUIRE;
         code_reg <= CODE_RESET;
         shrink_reg <= 4'h0;
         lol_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         code_reg <= code_next;
         shrink_reg <= shrink_next;
         lol_reg <= lol_next;
      end
   end

   // sticky flag and pin selection; a new loss beats a clear
   logic clr_arm_reg, clr_arm_next, clr_pulse, sticky_next;
   logic lol_pin_next, floop_next, ploop_next;
   always_comb begin
      clr_arm_next = secondary_control_word[CB_CLR_BIT];
      clr_pulse = clr_arm_reg & ~secondary_control_word[CB_CLR_BIT];
      sticky_next = lol_sticky;
      if (clr_pulse)
         sticky_next = 1'b0;
      if (lol_next)
         sticky_next = 1'b1;
      lol_pin_next = secondary_control_word[CB_MIRROR_BIT] ? sticky_next : lol_next;
      floop_next = lol_next;
      ploop_next = ~lol_next;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clr_arm_reg <= 1'b0;
         lol_sticky <= 1'b1;
         loss_of_lock <= 1'b1;
         freq_loop_en <= 1'b1;
         phase_loop_en <= 1'b0;
         osc_code <= CODE_RESET;
      end else begin
         clr_arm_reg <= clr_arm_next;
         lol_sticky <= sticky_next;
         loss_of_lock <= lol_pin_next;
         freq_loop_en <= floop_next;
         phase_loop_en <= ploop_next;
         osc_code <= code_next;
      end
   end

   // checks
   a_lol_on_error: assert property (@(posedge clk) disable iff (rst)
      eval_reg && state_reg == CFL_LOCKED && out_of_lock |=> lol_reg && state_reg == CFL_ACQUIRE)
      else $error("lock loss not raised on large error");
   a_floor_restart: assert property (@(posedge clk) disable iff (rst)
      eval_reg && state_reg == CFL_LOCKED && out_of_lock |=> osc_code == CODE_FLOOR)
      else $error("sweep did not restart at floor");
   a_raise_when_low: assert property (@(posedge clk) disable iff (rst)
      eval_reg && state_reg == CFL_ACQUIRE && !in_lock && too_low && code_reg < CODE_CEIL
      |=> code_reg > $past(code_reg))
      else $error("code not raised while low");
   a_step_shrinks: assert property (@(posedge clk) disable iff (rst)
      eval_reg && state_reg == CFL_ACQUIRE && !in_lock && too_low && near1
      |=> code_reg - $past(code_reg) <= (CODE_W'(1) << SH_MEDIUM))
      else $error("step not reduced near target");
   a_lol_release: assert property (@(posedge clk) disable iff (rst)
      eval_reg && state_reg == CFL_ACQUIRE && in_lock |=> !lol_reg ##1 phase_loop_en)
      else $error("lock loss not released");
   a_loop_handover: assert property (@(posedge clk) disable iff (rst)
      $fell(lol_reg) |-> phase_loop_en && !freq_loop_en)
      else $error("loops not handed over");
   a_code_range: assert property (@(posedge clk) disable iff (rst)
      osc_code >= CODE_FLOOR && osc_code <= CODE_CEIL)
      else $error("code out of range");
   a_hold_acquire: assert property (@(posedge clk) disable iff (rst)
      state_reg == CFL_ACQUIRE && !(eval_reg && in_lock) |=> lol_reg)
      else $error("lock loss dropped early");
   a_data_target: assert property (@(posedge clk) disable iff (rst)
      !primary_control_word[CA_AID_BIT] |-> tgt == TGT_W'(data_cnt))
      else $error("normal mode used reference");
   a_sticky_holds: assert property (@(posedge clk) disable iff (rst)
      lol_sticky && !clr_pulse |=> lol_sticky)
      else $error("sticky flag lost");
   a_pin_mirror: assert property (@(posedge clk) disable iff (rst)
      secondary_control_word[CB_MIRROR_BIT] |=> loss_of_lock == lol_sticky)
      else $error("pin does not mirror sticky flag");
endmodule
`default_nettype wire

// ### pkg/cfl_pkg.sv
// cfl_pkg: constants shared by the frequency acquisition / lock detector.
// assumes a single 250 MHz clock; oscillator tuning is a linear code word.
package cfl_pkg;
   // clock and measurement window
   localparam int CLK_MHZ     = 250;
   localparam int WIN_TIME_US = 256;                    // measurement window length
   localparam int WIN_CYC_DEF = WIN_TIME_US * CLK_MHZ;  // cycles per window
   localparam int WIN_CW      = 24;                     // window counter width
   localparam int CNT_W       = 16;                     // edges per window
   localparam int TGT_W       = 32;                     // target after ratio shift
   // oscillator code: 1/64 MHz per lsb, 10 MHz floor, 2700 MHz ceiling
   localparam int                 CODE_W     = 18;
   localparam logic [CODE_W-1:0] CODE_FLOOR = 18'h0_0280;
   localparam logic [CODE_W-1:0] CODE_CEIL  = 18'h2_A300;
   localparam logic [CODE_W-1:0] CODE_RESET = CODE_FLOOR;
   // step sizes as shifts: coarse, medium, fine
   localparam logic [3:0] SH_COARSE = 4'h0E;
   localparam logic [3:0] SH_MEDIUM = 4'h08;
   localparam logic [3:0] SH_FINE   = 4'h02;
   localparam logic [3:0] SH_MAXOFF = 4'h0F;
   localparam int         NEAR_DIV1 = 16;   // error at most 1/16 of target
   localparam int         NEAR_DIV2 = 256;  // error at most 1/256 of target
   // ppm thresholds
   localparam longint PPM_SCALE  = 1000000;
   localparam longint PPM_ASSERT = 1000;
   localparam longint PPM_LOCK   = 250;
   // control word fields
   localparam int CA_AID_BIT    = 0;
   localparam int CA_RATIO_LO   = 2;
   localparam int CA_RANGE_LO   = 6;
   localparam int CB_CLR_BIT    = 6;
   localparam int CB_MIRROR_BIT = 7;
   typedef enum logic [0:0] {CFL_ACQUIRE, CFL_LOCKED} cfl_state_t;
endpackage

// ### hw/cfl_edge_counter.sv
// cfl_edge_counter: counts edges of an asynchronous pin over a window.
// assumes win_end is a one-cycle pulse on clk; pin is from any domain.
`timescale 1ns/1ns
`default_nettype none
module cfl_edge_counter #(
   parameter int CW         = 16,
   parameter bit BOTH_EDGES = 1'b0
) (
   input  wire logic          clk,
   input  wire logic          rst,
   input  wire logic          pin_async,
   input  wire logic          win_end,
   output logic [CW-1:0]      count
);
   import cfl_pkg::*;
   generate
      if (CW < 4) begin : g_chk
         $error("cfl_edge_counter: CW too small");
      end
   endgenerate

   logic [2:0]    sync_reg, sync_next;
   logic [CW-1:0] acc_reg, acc_next, count_next;
   logic          edge_seen;

   // edge detector compares stages two and three; first stage only feeds stage two
   always_comb begin
      sync_next = {sync_reg[1:0], pin_async};
      edge_seen = BOTH_EDGES ? (sync_reg[1] ^ sync_reg[2]) : (sync_reg[1] & ~sync_reg[2]);
      count_next = count;
      acc_next = acc_reg;
      if (win_end) begin
         // a full accumulator must not wrap to zero on the closing edge
         count_next = (acc_reg == {CW{1'b1}}) ? acc_reg : acc_reg + CW'(edge_seen);
         acc_next = '0;
      end else if (edge_seen && acc_reg != {CW{1'b1}}) begin
         acc_next = acc_reg + 1'b1;   // saturate, never wrap
      end
   end

   // register stage
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_reg <= 3'h0;
         acc_reg <= '0;
         count <= '0;
      end else begin
         sync_reg <= sync_next;
         acc_reg <= acc_next;
         count <= count_next;
      end
   end
endmodule
`default_nettype wire

// ### sim/cfl_link_model.sv
// cfl_link_model: far-side stand-in giving data, oscillator tick and reference pins.
// assumes a 4 ns system clock; edges land 1 ns past a multiple of 16 ns, except tick falls at 9 ns past.
`timescale 1ns/1ns
`default_nettype none
module cfl_link_model (
   input  wire logic [15:0] drop_every,
   output logic             osc_tick_pin,
   output logic             data_pin,
   output logic             acquisition_aid_clock
);
   int unsigned pulse_idx;

   // restart the drop pattern so a new setting is exact from its first window
   always @(drop_every)
      pulse_idx = 0;

   // one data transition and one tick every 16 ns, reference rises every 64 ns
   initial begin
      osc_tick_pin          = 1'b0;
      data_pin              = 1'b0;
      acquisition_aid_clock = 1'b0;
      pulse_idx             = 0;
      #1;
      forever begin
         // dropping a tick mid-pattern makes the oscillator look slow by one count
         if (drop_every == 16'h0000 || pulse_idx % drop_every != drop_every / 2)
            osc_tick_pin = 1'b1;
         pulse_idx++;
         data_pin = ~data_pin;
         if (data_pin)
            acquisition_aid_clock = ~acquisition_aid_clock;
         #8 osc_tick_pin = 1'b0;
         #8;
      end
   end
endmodule
`default_nettype wire

// ### sim/cfl_lock_detector_tb_top.sv
// cfl_lock_detector_tb_top: self-checking bench for the lock detector.
// assumes outputs change only at window start or just after a sample; they are sampled mid-window.
`timescale 1ns/1ns
`default_nettype none
module cfl_lock_detector_tb_top;
   import cfl_pkg::*;
   localparam int W = 4096;   // short window, 1024 data edges: one count is 977 ppm
   localparam logic [CODE_W-1:0] C1 = CODE_FLOOR + (18'h0_0001 << SH_COARSE);
   localparam logic [CODE_W-1:0] C2 = C1 + (18'h0_0001 << SH_COARSE);
   localparam logic [CODE_W-1:0] C3 = C2 + (18'h0_0001 << SH_MEDIUM);
   localparam logic [CODE_W-1:0] C4 = C3 + (18'h0_0001 << SH_FINE);
   localparam logic [CODE_W-1:0] C5 = C4 + (18'h0_0001 << SH_FINE);
   // one overshoot halves the coarse step
   localparam logic [CODE_W-1:0] C6 = CODE_FLOOR + (18'h0_0001 << (SH_COARSE - 4'h1));

   logic              clk;
   logic              rst;
   logic [7:0]        primary_control_word;
   logic [7:0]        secondary_control_word;
   logic [15:0]       drop_every;
   logic              osc_tick_pin;
   logic              data_pin;
   logic              acquisition_aid_clock;
   logic              loss_of_lock;
   logic              lol_sticky;
   logic              freq_loop_en;
   logic              phase_loop_en;
   logic [CODE_W-1:0] osc_code;
   int                cyc;
   int                n_errors;
   int                n_checks;
   int                n_steps;
   logic [CODE_W+3:0] exp_q[$];

   cfl_link_model link (
      .drop_every            (drop_every),
      .osc_tick_pin          (osc_tick_pin),
      .data_pin              (data_pin),
      .acquisition_aid_clock (acquisition_aid_clock)
   );

   cfl_lock_detector #(.WINDOW_CYC(W)) dut (
      .clk                    (clk),
      .rst                    (rst),
      .osc_tick_pin           (osc_tick_pin),
      .data_pin               (data_pin),
      .acquisition_aid_clock  (acquisition_aid_clock),
      .primary_control_word   (primary_control_word),
      .secondary_control_word (secondary_control_word),
      .loss_of_lock           (loss_of_lock),
      .lol_sticky             (lol_sticky),
      .freq_loop_en           (freq_loop_en),
      .phase_loop_en          (phase_loop_en),
      .osc_code               (osc_code)
   );

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // cycles since reset release, to place stimulus and samples in each window
   always @(posedge clk or posedge rst)
      if (rst)
         cyc <= 0;
      else
         cyc <= cyc + 1;

   task automatic check(input logic [CODE_W+3:0] exp, input logic [CODE_W+3:0] got);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // count settings go in early so this window's counts reflect them; mirror
   // and clear act at once, so they wait until this window's sample is taken
   // and then show in the next sample, beside the note queued here
   task automatic step(input logic [15:0] drop, input logic [7:0] pcw, input logic mir,
                       input logic clr, input logic [CODE_W+3:0] exp);
      do @(posedge clk); while (cyc % W != 16);
      #1;
      drop_every = drop;
      primary_control_word = pcw[0] ? pcw : {7'($urandom()), 1'b0};
      do @(posedge clk); while (cyc % W != W / 2);
      #1;
      exp_q.push_back(exp);
      secondary_control_word = {mir, clr, 6'($urandom())};
      if (clr) begin
         @(posedge clk);
         #1;
         secondary_control_word[6] = 1'b0;
      end
   endtask

   // outputs change only at window start or just after the sample, so mid-window sampling is race free
   always @(posedge clk)
      if (!rst && cyc % W == W / 2 && exp_q.size() > 0) begin
         check(exp_q.pop_front(), {loss_of_lock, lol_sticky, freq_loop_en, phase_loop_en,
                                   osc_code});
         n_steps++;
         $display("test %0d done", n_steps);
      end

   // flags are lol, sticky, freq loop, phase loop
   initial begin
      rst = 1'b1;
      drop_every = 16'h0002;
      primary_control_word = 8'h00;
      secondary_control_word = 8'h00;
      n_errors = 0;
      n_checks = 0;
      n_steps = 0;
      void'($urandom(32'hcf7c9bf5));
      repeat (12) @(posedge clk);
      #1 rst = 1'b0;
      exp_q.push_back({4'hE, CODE_FLOOR});
      step(16'h0002, 8'h00, 1'b0, 1'b0, {4'hE, C1});
      step(16'h0002, 8'h00, 1'b0, 1'b0, {4'hE, C2});
      step(16'h0020, 8'h00, 1'b0, 1'b0, {4'hE, C3});
      step(16'h0200, 8'h00, 1'b0, 1'b0, {4'hE, C4});
      step(16'h0400, 8'h00, 1'b0, 1'b0, {4'hE, C5});
      step(16'h0000, 8'h00, 1'b0, 1'b0, {4'h5, C5});
      step(16'h0400, 8'h00, 1'b0, 1'b1, {4'h1, C5});
      step(16'h0200, 8'h00, 1'b0, 1'b0, {4'hE, CODE_FLOOR});
      step(16'h0000, 8'h00, 1'b1, 1'b0, {4'hD, CODE_FLOOR});
      step(16'h0000, 8'h00, 1'b1, 1'b1, {4'h1, CODE_FLOOR});
      step(16'h0000, 8'h0D, 1'b0, 1'b0, {4'hE, CODE_FLOOR});
      step(16'h0000, 8'h09, 1'b0, 1'b0, {4'h5, CODE_FLOOR});
      step(16'h0000, 8'h4D, 1'b0, 1'b0, {4'h5, CODE_FLOOR});
      step(16'h0200, 8'h4D, 1'b0, 1'b0, {4'hE, CODE_FLOOR});
      step(16'h0000, 8'h05, 1'b0, 1'b0, {4'hE, CODE_FLOOR});
      step(16'h0002, 8'h00, 1'b0, 1'b0, {4'hE, C6});
      repeat (W + 8) @(posedge clk);
      end_sim();
   end

   // seventeen windows of tests plus margin
   initial begin
      #(20 * W * 4);
      n_errors++;
      $display("watchdog expired");
      end_sim();
   end
endmodule
`default_nettype wire
